// *** rtl/adfr_pkg.sv ***
/*
 * Constants for the analog fault flag bank: register addresses, field positions, reset words.
 * Assumes a 22-bit read word with the register address in bits 20:16.
 */
package adfr_pkg;
    localparam int ADDR_W = 5;
    localparam int WORD_W = 22;
    localparam logic [4:0] ANALOG_FLAGS_ADDR = 5'h15;
    localparam logic [4:0] SUMMARY_ADDR = 5'h16;
    localparam logic [21:0] ANALOG_FLAGS_RESET = 22'h150000;
    localparam logic [21:0] SUMMARY_RESET = 22'h160000;
    localparam int FAULT_PIN_BIT = 21;
    localparam int ADDR_LSB = 16;
    localparam int ANALOG_SUM_BIT = 19;
    localparam int LOGIC_SUM_BIT = 20;
    localparam int REGULATOR_BIT = 0;
    localparam int SUPPLY_BIT = 1;
    localparam int REF_IN_BIT = 2;
    localparam int REF_OUT_BIT = 3;
    localparam int DIE_TEMP_BIT = 4;
    localparam int VOUT_SHORT_BIT = 6;
    localparam int IOUT_OPEN_BIT = 7;
    localparam int RAMP_BUSY_BIT = 7;
    localparam logic [7:0] FLAG_MASK = 8'hdf;
endpackage

// *** rtl/adfr_flag_bank.sv ***
/*
 * Sticky analog fault flag register and summary status register.
 * Assumes a serial port front end that presents decoded single-cycle read and write
 * strobes with a 5-bit address and 16-bit write data, all synchronous to clk.
 * Comparator inputs are levels already synchronous to clk.
 * Reads answer one cycle after the strobe with a registered word held until the next read.
 * Only writes to 0x15 and low diag_enable bits clear flags; writes elsewhere and reads have no side effect.
 * The digital diagnostic flags arrive as levels from the logic that owns them.
 */
module adfr_flag_bank (
    input wire logic clk,                 // 125 MHz clock
    input wire logic reset_n,             // async reset, active low
    input wire logic rd_stb,              // read strobe
    input wire logic wr_stb,              // write strobe
    input wire logic [4:0] addr,          // register address
    input wire logic [15:0] wr_data,      // write data bits 15:0
    output logic [21:0] rd_data,          // read word, registered
    output logic rd_valid,                // read word valid, one-cycle pulse
    input wire logic regulator_fault,     // regulator node out of window or limiting
    input wire logic supply_fault,        // internal supply node out of window
    input wire logic ref_in_fault,        // reference input out of window
    input wire logic ref_out_fault,       // reference output out of window or limiting
    input wire logic die_overtemp,        // die temperature comparator
    input wire logic vout_short,          // voltage output short detect
    input wire logic iout_open,           // current output open detect
    input wire logic iout_headroom_low,   // current driver lacks headroom
    input wire logic [7:0] diag_enable,   // per flag diagnostic enables
    input wire logic [15:0] logic_fault_flags, // digital diagnostic flags
    input wire logic fault_pin            // present fault pin level
);
    // sticky flag register and its next value
    logic [7:0] analog_fault_flags;
    wire logic [7:0] next_flags;

    // read path: next read word and its valid pulse
    wire logic [21:0] next_rd_data;
    wire logic next_rd_valid;

    // address decode
    wire logic flags_hit;
    wire logic summary_hit;
    wire logic flags_write;
    wire logic flags_read;
    wire logic summary_read;

    // comparator events, enables and clears, one bit per flag position
    wire logic [7:0] events;
    wire logic [7:0] flag_enable;
    wire logic [7:0] clear_mask;
    wire logic [7:0] visible_flags;

    // one named flag per flag position except reserved bit 5, as seen by a read
    wire logic regulator_node_flag;
    wire logic internal_supply_node_flag;
    wire logic ref_input_node_flag;
    wire logic ref_output_node_flag;
    wire logic die_temp_flag;
    wire logic voltage_out_short_flag;
    wire logic current_out_open_flag;

    // summary bits
    wire logic [15:0] summed_logic_flags;
    wire logic analog_summary_flag;
    wire logic logic_summary_flag;

    // read words
    wire logic [21:0] flags_fields;
    wire logic [21:0] summary_fields;
    wire logic [21:0] flags_word;
    wire logic [21:0] summary_word;

    // true when the request address selects the given register
    function automatic logic adfr_addr_hit(
        input logic [4:0] req_addr,
        input logic [4:0] reg_addr
    );
        return req_addr == reg_addr;
    endfunction

    // a one-bit value placed at a field position of the read word
    function automatic logic [21:0] adfr_bit_at(
        input logic value,
        input int pos
    );
        return 22'(value) << pos;
    endfunction

    // read word: reset word with its address field, plus pin level and live fields
    function automatic logic [21:0] adfr_read_word(
        input logic [21:0] base,
        input logic pin,
        input logic [21:0] fields
    );
        logic [21:0] pin_field;
        pin_field = adfr_bit_at(pin, adfr_pkg::FAULT_PIN_BIT);
        return base | pin_field | fields;
    endfunction

    // next state of one sticky flag; a live event beats a clear in the same cycle
    function automatic logic adfr_next_flag(
        input logic flag,
        input logic event_now,
        input logic clear,
        input logic enable
    );
        logic kept;
        kept = flag & ~clear;
        return (kept | event_now) & enable;
    endfunction

    // requests that select one of the two registers
    assign flags_hit = adfr_addr_hit(addr, adfr_pkg::ANALOG_FLAGS_ADDR);
    assign summary_hit = adfr_addr_hit(addr, adfr_pkg::SUMMARY_ADDR);
    assign flags_write = wr_stb & flags_hit;
    assign flags_read = rd_stb & flags_hit;
    assign summary_read = rd_stb & summary_hit;

    // comparator levels map onto flag positions; iout_open and iout_headroom_low share bit 7, bit 5 has none
    assign events[adfr_pkg::REGULATOR_BIT] = regulator_fault;
    assign events[adfr_pkg::SUPPLY_BIT] = supply_fault;
    assign events[adfr_pkg::REF_IN_BIT] = ref_in_fault;
    assign events[adfr_pkg::REF_OUT_BIT] = ref_out_fault;
    assign events[adfr_pkg::DIE_TEMP_BIT] = die_overtemp;
    assign events[5] = 1'b0;
    assign events[adfr_pkg::VOUT_SHORT_BIT] = vout_short;
    assign events[adfr_pkg::IOUT_OPEN_BIT] = iout_open | iout_headroom_low;

    // reserved bit 5 never enables, so it never sets and always reads zero
    assign flag_enable = diag_enable & adfr_pkg::FLAG_MASK;

    // write-one-to-clear; zero bits and writes to other addresses leave flags alone
    assign clear_mask = flags_write
        ? (wr_data[7:0] & adfr_pkg::FLAG_MASK) : 8'h00;

    // next value of every flag, bit by bit; a disabled flag is dropped
    for (genvar i = 0; i < 8; i++) begin : g_flag
        assign next_flags[i] = adfr_next_flag(analog_fault_flags[i], events[i],
            clear_mask[i], flag_enable[i]);
    end

    // flag register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            analog_fault_flags <= 8'h00;
        end else begin
            analog_fault_flags <= next_flags;
        end
    end

    // a read shows only enabled flags
    assign visible_flags = analog_fault_flags & flag_enable;
    assign regulator_node_flag = visible_flags[adfr_pkg::REGULATOR_BIT];
    assign internal_supply_node_flag = visible_flags[adfr_pkg::SUPPLY_BIT];
    assign ref_input_node_flag = visible_flags[adfr_pkg::REF_IN_BIT];
    assign ref_output_node_flag = visible_flags[adfr_pkg::REF_OUT_BIT];
    assign die_temp_flag = visible_flags[adfr_pkg::DIE_TEMP_BIT];
    assign voltage_out_short_flag = visible_flags[adfr_pkg::VOUT_SHORT_BIT];
    assign current_out_open_flag = visible_flags[adfr_pkg::IOUT_OPEN_BIT];

    // bit 19: any visible analog flag; only bits 7:0 exist of the ored span 13:0
    assign analog_summary_flag = |visible_flags;

    // bit 20: any logic flag except the ramp busy indication
    assign summed_logic_flags = logic_fault_flags
        & ~(16'h0001 << adfr_pkg::RAMP_BUSY_BIT);
    assign logic_summary_flag = |summed_logic_flags;

    // bit 21 of both words is the pin level at the read edge, not a stored copy
    assign flags_fields = {14'h0000, current_out_open_flag, voltage_out_short_flag, 1'b0,
        die_temp_flag, ref_output_node_flag, ref_input_node_flag, internal_supply_node_flag,
        regulator_node_flag};
    assign flags_word = adfr_read_word(adfr_pkg::ANALOG_FLAGS_RESET, fault_pin,
        flags_fields);

    // the address echo sets bit 20 too, so bit 20 reads high whatever the logic flags
    assign summary_fields = adfr_bit_at(logic_summary_flag, adfr_pkg::LOGIC_SUM_BIT)
        | adfr_bit_at(analog_summary_flag, adfr_pkg::ANALOG_SUM_BIT);
    assign summary_word = adfr_read_word(adfr_pkg::SUMMARY_RESET, fault_pin,
        summary_fields);

    // other addresses read as zero
    assign next_rd_data = flags_read ? flags_word
        : summary_read ? summary_word
        : 22'h000000;
    assign next_rd_valid = rd_stb;

    // valid pulse follows every read request by one cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= next_rd_valid;
        end
    end

    // read word is held until the next read request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 22'h000000;
        end else if (rd_stb) begin
            rd_data <= next_rd_data;
        end
    end

endmodule

// *** test/adfr_flag_bank_asserts.sv ***
/* checks on the fault flag bank read words and valid pulse;
   bound onto every adfr_flag_bank instance, it sees only that block's ports */
module adfr_flag_bank_asserts (
    input wire logic clk, reset_n, rd_stb, wr_stb, fault_pin, // clock, reset, strobes, pin
    input wire logic vout_short, iout_open, iout_headroom_low, // comparator levels
    input wire logic [4:0] addr, // register address
    input wire logic [7:0] diag_enable, // flag enables
    input wire logic [21:0] rd_data, // read word
    input wire logic rd_valid // read word valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire rd15 = rd_stb && addr == 5'h15;
    wire rd16 = rd_stb && addr == 5'h16;
    valid_pulse_a: assert property (rd_stb |=> rd_valid) else $error("no read valid");
    flags_word_a: assert property (rd15 |=> rd_data[20:8] == 13'h1500 && !rd_data[5])
        else $error("flag word fixed bits wrong");
    sum_word_a: assert property (rd16 |=> rd_data[18:0] == 19'h60000) else $error("sum word");
    pin_echo_a: assert property (rd15 || rd16 |=> rd_data[21] == $past(fault_pin))
        else $error("pin bit wrong");
    mask_off_a: assert property (rd15 |=> (rd_data[7:0] & ~$past(diag_enable)) == 8'h00)
        else $error("disabled flag reads one");
    vout_set_a: assert property (rd15 && diag_enable[6]
        && $past(vout_short && diag_enable[6] && reset_n) |=> rd_data[6]) else $error("vout");
    iout_set_a: assert property (rd15 && diag_enable[7]
        && $past((iout_open || iout_headroom_low) && diag_enable[7] && reset_n) |=> rd_data[7])
        else $error("iout flag not set");
    ana_sum_a: assert property ((rd15 && !wr_stb) ##1 (!wr_stb && $stable(diag_enable)) ##1
        (rd16 && $stable(diag_enable) && rd_data[13:0] != 14'h0) |=> rd_data[19])
        else $error("summary bit low");
    cover property (rd15);
    cover property (wr_stb && addr == 5'h15);
    cover property (rd16);
endmodule
bind adfr_flag_bank adfr_flag_bank_asserts i_chk (.*);

// *** test/adfr_flag_bank_tb.sv ***
/* bench for adfr_flag_bank; drives every input at the falling edge of clk
   and assumes the block answers a read one cycle after the strobe */
module adfr_flag_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, rd_stb, wr_stb, fault_pin, rd_valid, regulator_fault, supply_fault;
    logic ref_in_fault, ref_out_fault, die_overtemp, vout_short, iout_open, iout_headroom_low;
    logic [4:0] addr;
    logic [7:0] f, diag_enable;
    logic [15:0] wr_data, logic_fault_flags;
    logic [21:0] rd_data;
    int compares, n_mismatch;
    // fault levels, enables, pin level, expected flag word
    logic [38:0] rows [11] = '{{8'h00, 8'hff, 1'b0, 22'h150000}, {8'h01, 8'hff, 1'b1, 22'h350001},
        {8'h02, 8'hff, 1'b0, 22'h150002}, {8'h04, 8'hff, 1'b0, 22'h150004},
        {8'h08, 8'hff, 1'b0, 22'h150008}, {8'h10, 8'hff, 1'b0, 22'h150010},
        {8'h20, 8'hff, 1'b0, 22'h150040}, {8'h40, 8'hff, 1'b0, 22'h150080},
        {8'h80, 8'hff, 1'b0, 22'h150080}, {8'hff, 8'h00, 1'b0, 22'h150000},
        {8'h03, 8'hfe, 1'b0, 22'h150002}};
    assign {iout_headroom_low, iout_open, vout_short, die_overtemp, ref_out_fault, ref_in_fault,
        supply_fault, regulator_fault} = f;
    adfr_flag_bank i_dut (.*);
    initial begin clk = 0; forever #4 clk = ~clk; end
    initial begin #5000; n_mismatch++; summarize(); end
    task automatic chk(logic [21:0] s, logic [21:0] e);
        compares++;
        if (s !== e) begin n_mismatch++; $display("MISMATCH %0t read %h want %h", $time, s, e); end
    endtask
    task automatic rd(logic [4:0] a, logic [21:0] e);
        addr = a; rd_stb = 1;
        @(negedge clk) rd_stb = 0;
        chk({21'h000000, rd_valid}, 22'h000001);
        @(negedge clk) chk(rd_data, e);
        chk({21'h000000, rd_valid}, 22'h000000);
    endtask
    task automatic wr(logic [15:0] d);
        addr = 5'h15; wr_data = d; wr_stb = 1;
        @(negedge clk) wr_stb = 0;
    endtask
    task automatic summarize();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {reset_n, rd_stb, wr_stb, addr, f, wr_data, logic_fault_flags, fault_pin} = '0;
        diag_enable = 8'hff;
        repeat (8) @(negedge clk);
        reset_n = 1;
        for (int i = 0; i < 11; i++) begin
            {f, diag_enable, fault_pin} = rows[i][38:22];
            @(negedge clk) f = 0;
            rd(5'h15, rows[i][21:0]);
            wr(16'h00ff);
        end
        diag_enable = 8'hff; logic_fault_flags = 16'h0080; f = 8'h20;
        @(negedge clk) f = 0;
        wr(16'hffbf);
        rd(5'h15, 22'h150040);
        addr = 5'h16;
        wr_data = 16'hffff;
        wr_stb = 1;
        @(negedge clk) wr_stb = 0;
        rd(5'h15, 22'h150040);
        rd(5'h17, 22'h000000);
        rd(5'h16, 22'h1e0000);
        wr(16'h0040);
        rd(5'h15, 22'h150000);
        rd(5'h16, 22'h160000);
        f = 8'h10;
        @(negedge clk) wr(16'h0010);
        rd(5'h15, 22'h150010);
        f = 0; reset_n = 0;
        @(negedge clk) chk(rd_data, 22'h000000);
        reset_n = 1;
        rd(5'h15, 22'h150000);
        fault_pin = 1;
        rd(5'h16, 22'h360000);
        summarize();
    end
endmodule
